// ==== state_save_pkg.sv ====
// constants, types and section layout of the state-save sequencer
package state_save_pkg;
   typedef enum logic [1:0] {
      OP_SAVE = 2'b00,
      OP_SAVE_SUP = 2'b01,
      OP_RESTORE = 2'b10,
      OP_RESTORE_SUP = 2'b11
   } op_t;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_CHECK = 3'b001,
      ST_FETCH = 3'b010,
      ST_MEM = 3'b011,
      ST_STORE = 3'b100,
      ST_END = 3'b101
   } state_t;
   // fault codes
   localparam logic [2:0] FLT_NONE = 3'h0;
   localparam logic [2:0] FLT_UNDEF = 3'h1;
   localparam logic [2:0] FLT_GP = 3'h2;
   localparam logic [2:0] FLT_MEM = 3'h3;
   localparam logic [2:0] FLT_VMEXIT = 3'h4;
   // component numbers
   localparam logic [4:0] CMP_MASK = 5'h05;
   localparam logic [4:0] CMP_UPPER = 5'h06;
   localparam logic [4:0] CMP_HIGH16 = 5'h07;
   localparam logic [4:0] CMP_TRACE = 5'h08;
   localparam logic [4:0] CMP_PKEY = 5'h09;
   localparam logic [4:0] CMP_DUTY = 5'h0D;
   localparam int NUM_SLOTS = 6;
   localparam logic [2:0] SLOT_NONE = 3'h6;
   // section offsets from the save-area base
   localparam logic [31:0] OFS_MASK = 32'h0000_0440;
   localparam logic [31:0] OFS_UPPER = 32'h0000_0480;
   localparam logic [31:0] OFS_HIGH16 = 32'h0000_0680;
   localparam logic [31:0] OFS_PKEY = 32'h0000_0A80;
   localparam logic [31:0] OFS_SUP = 32'h0000_0000;
   // section sizes in bytes
   localparam logic [31:0] SZ_MASK = 32'h0000_0040;
   localparam logic [31:0] SZ_UPPER = 32'h0000_0200;
   localparam logic [31:0] SZ_HIGH16 = 32'h0000_0400;
   localparam logic [31:0] SZ_TRACE = 32'h0000_0080;
   localparam logic [31:0] SZ_PKEY = 32'h0000_0008;
   localparam logic [31:0] SZ_DUTY = 32'h0000_0008;
   // word counts (8-byte words)
   localparam logic [7:0] WD_UPPER_LOW = 8'h20;
   localparam logic [7:0] WD_TRACE_REGS = 8'h09;
   localparam logic [7:0] WD_ONE = 8'h01;
   localparam logic [31:0] UPPER_LOW_BYTES = 32'h0000_0100;
   localparam int TRACE_EN_POS = 0;
   localparam logic [7:0] BE_FULL = 8'hFF;
   localparam logic [7:0] BE_PKEY = 8'h0F;
endpackage

// ==== section_map.sv ====
// section base, size and word count of one state component
`timescale 1ns/1ns
module section_map
   import state_save_pkg::*;
(
   input wire logic [4:0] comp_i,
   input wire logic mode64_i,
   input wire logic restore_i,
   output logic [31:0] base_o,
   output logic [31:0] size_o,
   output logic [7:0] words_o
);
   always_comb begin
      base_o = OFS_SUP;
      size_o = 32'h0;
      if (comp_i == CMP_MASK) begin
         base_o = OFS_MASK;
         size_o = SZ_MASK;
      end else if (comp_i == CMP_UPPER) begin
         base_o = OFS_UPPER;
         size_o = SZ_UPPER;
      end else if (comp_i == CMP_HIGH16) begin
         base_o = OFS_HIGH16;
         size_o = SZ_HIGH16;
      end else if (comp_i == CMP_TRACE) begin
         size_o = SZ_TRACE;
      end else if (comp_i == CMP_PKEY) begin
         base_o = OFS_PKEY;
         size_o = SZ_PKEY;
      end else if (comp_i == CMP_DUTY) begin
         size_o = SZ_DUTY;
      end
      words_o = size_o[10:3];
      // upper half of registers 8-15 only in 64-bit mode
      if (comp_i == CMP_UPPER && !mode64_i) begin
         words_o = WD_UPPER_LOW;
      end
      // high-sixteen section untouched outside 64-bit mode
      if (comp_i == CMP_HIGH16 && !mode64_i) begin
         words_o = 8'h00;
      end
      // restore loads only the nine trace registers
      if (comp_i == CMP_TRACE && restore_i) begin
         words_o = WD_TRACE_REGS;
      end
   end
endmodule // section_map

// ==== word_map.sv ====
// register index, word and section byte offset of one transfer step
`timescale 1ns/1ns
module word_map
   import state_save_pkg::*;
(
   input wire logic [4:0] comp_i,
   input wire logic [7:0] step_i,
   input wire logic restore_i,
   output logic [4:0] idx_o,
   output logic [2:0] word_o,
   output logic [31:0] offset_o
);
   always_comb begin
      idx_o = 5'h0;
      word_o = 3'h0;
      offset_o = {21'h0, step_i, 3'h0};
      if (comp_i == CMP_MASK) begin
         // mask register i at bytes 8i+7:8i
         idx_o = step_i[4:0];
      end else if (comp_i == CMP_UPPER) begin
         // upper half of register i at bytes 32i+31:32i
         idx_o = {1'b0, step_i[5:2]};
         word_o = {1'b1, step_i[1:0]};
      end else if (comp_i == CMP_HIGH16) begin
         // register i at bytes 64(i-16)+63:64(i-16)
         idx_o = {1'b1, step_i[6:3]};
         word_o = step_i[2:0];
      end else if (comp_i == CMP_TRACE) begin
         // nine registers 8 bytes each; control loaded last on restore
         idx_o = step_i[4:0];
         if (restore_i) begin
            idx_o = (step_i == 8'h08) ? 5'h0 : 5'(step_i + 8'h01);
         end
         offset_o = {24'h0, idx_o, 3'h0};
      end
   end
endmodule // word_map

// ==== state_save_seq.sv ====
// save and restore sequencer for the extended state components
`timescale 1ns/1ns
module state_save_seq
   import state_save_pkg::*;
(
   // clock and reset
   input wire logic REF_CLK_I,
   input wire logic RESET_N_I,
   // instruction request
   input wire logic START_I,
   input wire logic [1:0] OP_I,
   input wire logic [13:0] REQ_MASK_I,
   input wire logic VM_EXIT_I,
   output logic BUSY_O,
   output logic DONE_O,
   output logic [2:0] FAULT_O,
   // configuration
   input wire logic OS_SAVE_ENABLE_I,
   input wire logic [13:0] USER_STATE_MASK_I,
   input wire logic [13:0] SUPERVISOR_STATE_MASK_I,
   input wire logic MODE64_I,
   output logic VEC_INSTR_OK_O,
   // identification query
   input wire logic [4:0] QUERY_SUB_I,
   output logic [31:0] QUERY_OFFSET_O,
   output logic [31:0] QUERY_SIZE_O,
   // trace enable
   input wire logic TRACE_ENABLE_BIT_I,
   output logic TRACE_EN_WR_O,
   output logic TRACE_EN_VAL_O,
   // key rights
   input wire logic [31:0] PROTECTION_KEY_RIGHTS_I,
   output logic [31:0] PKEY_CHECK_O,
   // register file port
   output logic RF_REQ_O,
   output logic RF_WE_O,
   output logic [4:0] RF_COMP_O,
   output logic [4:0] RF_IDX_O,
   output logic [2:0] RF_WORD_O,
   output logic [63:0] RF_WDATA_O,
   input wire logic [63:0] RF_RDATA_I,
   // memory port
   output logic MEM_REQ_O,
   output logic MEM_WE_O,
   output logic [31:0] MEM_ADDR_O,
   output logic [7:0] MEM_BE_O,
   output logic [63:0] MEM_WDATA_O,
   input wire logic [63:0] MEM_RDATA_I,
   input wire logic MEM_ACK_I,
   input wire logic MEM_FAULT_I
);
   state_t state_reg;
   op_t op_reg;
   logic [13:0] rfbm_reg;
   logic mode_reg;
   logic [5:0] act_reg;
   logic [5:0] act_next;
   logic [2:0] slot_reg;
   logic [7:0] step_reg;
   logic [63:0] data_reg;
   logic trace_orig_reg;
   logic trace_clr_reg;
   logic is_sup;
   logic is_restore;
   logic vec_ok;
   logic [4:0] comp;
   logic [31:0] base;
   logic [31:0] offset;
   logic [7:0] words;
   logic last_word;
   logic [2:0] nxt_slot;
   logic [2:0] first_slot;
   logic abort;
   logic trace_gp;

   function automatic logic [4:0] slot_comp(input logic [2:0] s);
      case (s)
         3'h0: slot_comp = CMP_MASK;
         3'h1: slot_comp = CMP_UPPER;
         3'h2: slot_comp = CMP_HIGH16;
         3'h3: slot_comp = CMP_TRACE;
         3'h4: slot_comp = CMP_PKEY;
         default: slot_comp = CMP_DUTY;
      endcase
   endfunction

   function automatic logic [2:0] find_slot(input logic [5:0] a,
                                            input logic [2:0] from);
      logic [2:0] r;
      r = SLOT_NONE;
      for (int i = NUM_SLOTS - 1; i >= 0; i--) begin
         if (a[i] && 3'(i) >= from) begin
            r = 3'(i);
         end
      end
      return r;
   endfunction

   // ----------------------------------------
   // enable conditions
   // ----------------------------------------
   assign is_sup = (op_reg == OP_SAVE_SUP) || (op_reg == OP_RESTORE_SUP);
   assign is_restore = op_reg[1];
   assign vec_ok = OS_SAVE_ENABLE_I && (&USER_STATE_MASK_I[7:5]);
   always_comb begin
      act_next[0] = rfbm_reg[5] && vec_ok;
      act_next[1] = rfbm_reg[6] && vec_ok;
      act_next[2] = rfbm_reg[7] && vec_ok && mode_reg;
      act_next[3] = is_sup && rfbm_reg[8] && OS_SAVE_ENABLE_I
                    && SUPERVISOR_STATE_MASK_I[8];
      act_next[4] = rfbm_reg[9] && OS_SAVE_ENABLE_I
                    && USER_STATE_MASK_I[9];
      act_next[5] = is_sup && rfbm_reg[13] && OS_SAVE_ENABLE_I
                    && SUPERVISOR_STATE_MASK_I[13];
   end
   assign trace_gp = (op_reg == OP_RESTORE_SUP) && act_next[3]
                     && TRACE_ENABLE_BIT_I;
   assign first_slot = find_slot(act_next, 3'h0);
   assign nxt_slot = find_slot(act_reg, 3'(slot_reg + 3'h1));

   // ----------------------------------------
   // layout
   // ----------------------------------------
   assign comp = slot_comp(slot_reg);
   section_map u_seq_map (
      .comp_i(comp),
      .mode64_i(mode_reg),
      .restore_i(is_restore),
      .base_o(base),
      .size_o(),
      .words_o(words)
   );
   word_map u_word_map (
      .comp_i(comp),
      .step_i(step_reg),
      .restore_i(is_restore),
      .idx_o(RF_IDX_O),
      .word_o(RF_WORD_O),
      .offset_o(offset)
   );
   assign last_word = (8'(step_reg + 8'h01) >= words);
   assign abort = VM_EXIT_I || (MEM_ACK_I && MEM_FAULT_I);

   // ----------------------------------------
   // ports
   // ----------------------------------------
   assign BUSY_O = (state_reg != ST_IDLE);
   assign RF_REQ_O = (state_reg == ST_FETCH) || (state_reg == ST_STORE);
   assign RF_WE_O = (state_reg == ST_STORE);
   assign RF_COMP_O = comp;
   assign RF_WDATA_O = data_reg;
   assign MEM_REQ_O = (state_reg == ST_MEM);
   assign MEM_WE_O = !is_restore;
   assign MEM_ADDR_O = base + offset;
   assign MEM_BE_O = (comp == CMP_PKEY) ? BE_PKEY : BE_FULL;
   assign MEM_WDATA_O = data_reg;

   // ----------------------------------------
   // sequencer
   // ----------------------------------------
   always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         state_reg <= ST_IDLE;
         slot_reg <= 3'h0;
         step_reg <= 8'h00;
         act_reg <= 6'h00;
         FAULT_O <= FLT_NONE;
         DONE_O <= 1'b0;
      end else begin
         DONE_O <= 1'b0;
         case (state_reg)
            ST_IDLE: begin
               if (START_I) begin
                  FAULT_O <= FLT_NONE;
                  state_reg <= ST_CHECK;
               end
            end
            ST_CHECK: begin
               act_reg <= act_next;
               slot_reg <= first_slot;
               step_reg <= 8'h00;
               if (!OS_SAVE_ENABLE_I) begin
                  FAULT_O <= FLT_UNDEF;
                  state_reg <= ST_END;
               end else if (trace_gp) begin
                  FAULT_O <= FLT_GP;
                  state_reg <= ST_END;
               end else if (first_slot == SLOT_NONE) begin
                  state_reg <= ST_END;
               end else begin
                  state_reg <= is_restore ? ST_MEM : ST_FETCH;
               end
            end
            ST_FETCH: state_reg <= ST_MEM;
            ST_MEM: begin
               if (abort) begin
                  FAULT_O <= VM_EXIT_I ? FLT_VMEXIT : FLT_MEM;
                  state_reg <= ST_END;
               end else if (MEM_ACK_I) begin
                  if (is_restore) begin
                     state_reg <= ST_STORE;
                  end else if (!last_word) begin
                     step_reg <= 8'(step_reg + 8'h01);
                     state_reg <= ST_FETCH;
                  end else begin
                     step_reg <= 8'h00;
                     slot_reg <= nxt_slot;
                     state_reg <= (nxt_slot == SLOT_NONE) ? ST_END : ST_FETCH;
                  end
               end
            end
            ST_STORE: begin
               if (!last_word) begin
                  step_reg <= 8'(step_reg + 8'h01);
                  state_reg <= ST_MEM;
               end else begin
                  step_reg <= 8'h00;
                  slot_reg <= nxt_slot;
                  state_reg <= (nxt_slot == SLOT_NONE) ? ST_END : ST_MEM;
               end
            end
            ST_END: begin
               DONE_O <= 1'b1;
               state_reg <= ST_IDLE;
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // request capture and key snapshot
   // ----------------------------------------
   always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         op_reg <= OP_SAVE;
         rfbm_reg <= 14'h0;
         mode_reg <= 1'b0;
         trace_orig_reg <= 1'b0;
         PKEY_CHECK_O <= 32'h0;
      end else if (state_reg == ST_IDLE) begin
         PKEY_CHECK_O <= PROTECTION_KEY_RIGHTS_I;
         if (START_I) begin
            op_reg <= op_t'(OP_I);
            rfbm_reg <= REQ_MASK_I & (USER_STATE_MASK_I
               | (OP_I[0] ? SUPERVISOR_STATE_MASK_I : 14'h0));
            mode_reg <= MODE64_I;
            trace_orig_reg <= TRACE_ENABLE_BIT_I;
         end
      end
   end

   // ----------------------------------------
   // data path
   // ----------------------------------------
   always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         data_reg <= 64'h0;
      end else if (state_reg == ST_FETCH) begin
         if (comp == CMP_TRACE && step_reg >= WD_TRACE_REGS) begin
            data_reg <= 64'h0;
         end else begin
            data_reg <= RF_RDATA_I;
         end
      end else if (state_reg == ST_MEM && MEM_ACK_I && is_restore) begin
         data_reg <= MEM_RDATA_I;
      end
   end

   // ----------------------------------------
   // trace enable handling
   // ----------------------------------------
   always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         TRACE_EN_WR_O <= 1'b0;
         TRACE_EN_VAL_O <= 1'b0;
         trace_clr_reg <= 1'b0;
      end else begin
         TRACE_EN_WR_O <= 1'b0;
         if (state_reg == ST_CHECK) begin
            trace_clr_reg <= 1'b0;
         end else if (state_reg == ST_MEM && op_reg == OP_SAVE_SUP) begin
            if (abort && trace_clr_reg) begin
               TRACE_EN_WR_O <= 1'b1;
               TRACE_EN_VAL_O <= trace_orig_reg;
            end else if (MEM_ACK_I && !abort && comp == CMP_TRACE
                         && step_reg == 8'h00) begin
               TRACE_EN_WR_O <= 1'b1;
               TRACE_EN_VAL_O <= 1'b0;
               trace_clr_reg <= 1'b1;
            end
         end
      end
   end

   // ----------------------------------------
   // query and instruction permit
   // ----------------------------------------
   logic [31:0] q_base;
   logic [31:0] q_size;
   section_map u_query_map (
      .comp_i(QUERY_SUB_I),
      .mode64_i(1'b1),
      .restore_i(1'b0),
      .base_o(q_base),
      .size_o(q_size),
      .words_o()
   );
   always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         QUERY_OFFSET_O <= 32'h0;
         QUERY_SIZE_O <= 32'h0;
         VEC_INSTR_OK_O <= 1'b0;
      end else begin
         QUERY_OFFSET_O <= q_base;
         QUERY_SIZE_O <= q_size;
         VEC_INSTR_OK_O <= vec_ok;
      end
   end

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   property p_vec_ok;
      @(posedge REF_CLK_I) disable iff (!RESET_N_I)
      (OS_SAVE_ENABLE_I && USER_STATE_MASK_I[7:5] == 3'b111)
         |=> VEC_INSTR_OK_O;
   endproperty
   a_vec_ok: assert property (p_vec_ok)
      else $error("vector permit missing");
   property p_trace_gp;
      @(posedge REF_CLK_I) disable iff (!RESET_N_I)
      (state_reg == ST_CHECK && OS_SAVE_ENABLE_I && trace_gp)
         |=> FAULT_O == FLT_GP && !MEM_REQ_O ##1 DONE_O;
   endproperty
   a_trace_gp: assert property (p_trace_gp)
      else $error("trace restore not refused");
   property p_trace_clear;
      @(posedge REF_CLK_I) disable iff (!RESET_N_I)
      (MEM_REQ_O && MEM_ACK_I && !abort && op_reg == OP_SAVE_SUP
         && comp == CMP_TRACE && step_reg == 8'h00)
         |=> TRACE_EN_WR_O && !TRACE_EN_VAL_O && !MEM_REQ_O;
   endproperty
   a_trace_clear: assert property (p_trace_clear)
      else $error("trace enable not cleared");
   property p_trace_back;
      @(posedge REF_CLK_I) disable iff (!RESET_N_I)
      (MEM_REQ_O && abort && op_reg == OP_SAVE_SUP && trace_clr_reg)
         |=> TRACE_EN_WR_O && TRACE_EN_VAL_O == trace_orig_reg;
   endproperty
   a_trace_back: assert property (p_trace_back)
      else $error("trace enable not put back");
   property p_high16;
      @(posedge REF_CLK_I) disable iff (!RESET_N_I)
      (MEM_REQ_O && !mode_reg) |-> comp != CMP_HIGH16;
   endproperty
   a_high16: assert property (p_high16)
      else $error("high vector section touched");
   property p_upper;
      @(posedge REF_CLK_I) disable iff (!RESET_N_I)
      (MEM_REQ_O && !mode_reg && comp == CMP_UPPER)
         |-> offset < UPPER_LOW_BYTES && RF_IDX_O < 5'h08;
   endproperty
   a_upper: assert property (p_upper)
      else $error("upper half 8-15 touched");
   property p_pkey;
      @(posedge REF_CLK_I) disable iff (!RESET_N_I)
      (BUSY_O && $past(BUSY_O)) |-> $stable(PKEY_CHECK_O);
   endproperty
   a_pkey: assert property (p_pkey)
      else $error("key rights changed in flight");
   property p_reserved;
      @(posedge REF_CLK_I) disable iff (!RESET_N_I)
      (MEM_REQ_O && !is_restore && comp == CMP_TRACE
         && step_reg >= WD_TRACE_REGS) |-> MEM_WDATA_O == 64'h0;
   endproperty
   a_reserved: assert property (p_reserved)
      else $error("reserved trace bytes not zero");
   property p_ctl_last;
      @(posedge REF_CLK_I) disable iff (!RESET_N_I)
      (RF_WE_O && comp == CMP_TRACE && RF_IDX_O == 5'h00)
         |-> step_reg == 8'h08;
   endproperty
   a_ctl_last: assert property (p_ctl_last)
      else $error("trace control loaded early");
endmodule // state_save_seq

// ==== save_area_model.sv ====
// save-area memory and register file model
`timescale 1ns/1ns
module save_area_model
   import state_save_pkg::*;
(
   // clock and control
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [3:0] dly_i,
   input wire logic flt_i,
   // memory side
   input wire logic req_i,
   input wire logic we_i,
   input wire logic [31:0] addr_i,
   input wire logic [7:0] be_i,
   input wire logic [63:0] wd_i,
   output logic [63:0] rd_o,
   output logic ack_o,
   output logic flt_o,
   // register file side
   input wire logic rf_req_i,
   input wire logic rf_we_i,
   input wire logic [12:0] rf_sel_i,
   output logic [63:0] rf_rd_o
);
   logic [63:0] mem [logic [31:0]];
   logic [7:0] bel [logic [31:0]];
   logic [3:0] cnt_reg;
   logic [63:0] nz_reg;
   int n_wr = 0;
   int n_rfw = 0;
   int n_hi = 0;
   // -----------------------------
   // answers, noise when idle
   // -----------------------------
   assign rf_rd_o = rf_req_i ? {51'h0, rf_sel_i} : nz_reg;
   assign flt_o = ack_o & flt_i;
   always @* begin
      rd_o = nz_reg;
      if (ack_o)
         rd_o = mem.exists(addr_i) ? mem[addr_i] : {addr_i, ~addr_i};
   end
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_reg <= 4'h0;
         ack_o <= 1'b0;
         nz_reg <= 64'h0;
      end else begin
         nz_reg <= {nz_reg[62:0], ~nz_reg[63]};
         ack_o <= 1'b0;
         cnt_reg <= 4'h0;
         if (req_i && !ack_o && cnt_reg < dly_i)
            cnt_reg <= cnt_reg + 4'h1;
         else if (req_i && !ack_o)
            ack_o <= 1'b1;
      end
   end
   // logs stores and register writes
   always @(posedge clk_i) begin
      if (ack_o && we_i && !flt_i) begin
         mem[addr_i] = wd_i;
         bel[addr_i] = be_i;
         n_wr++;
      end
      if (rf_req_i && rf_we_i) begin
         n_rfw++;
         if (rf_sel_i[12:8] == CMP_HIGH16 ||
             (rf_sel_i[12:8] == CMP_UPPER && rf_sel_i[7:3] >= 5'h08))
            n_hi++;
      end
   end
endmodule // save_area_model

// ==== extended_state_save_layout_tb_top.sv ====
// self-checking bench of the state-save sequencer
`timescale 1ns/1ns
module extended_state_save_layout_tb_top
   import state_save_pkg::*;
;
   logic clk, rst_n, start, vm_exit, os_en, m64, tr_en, flt;
   logic busy, done, vec_ok, tr_wr, tr_val, rf_req, rf_we;
   logic m_req, m_we, m_ack, m_flt;
   logic [1:0] op;
   logic [13:0] req, um, sm;
   logic [4:0] sub, rf_comp, rf_idx;
   logic [3:0] dly;
   logic [2:0] fault, rf_word;
   logic [7:0] m_be;
   logic [31:0] protection_key_rights, q_ofs, q_sz, pk_chk, m_addr;
   logic [63:0] rf_wd, rf_rd, m_wd, m_rd;
   int num_errors = 0, n_tests = 0, cyc = 0, wr0, rfw0, hi0, at_clr, t;
   logic [4:0] subs [7] = '{CMP_MASK, CMP_UPPER, CMP_HIGH16, CMP_TRACE,
      CMP_PKEY, CMP_DUTY, 5'h0A};
   logic [31:0] ofs [7] = '{OFS_MASK, OFS_UPPER, OFS_HIGH16, OFS_SUP,
      OFS_PKEY, OFS_SUP, 32'h0};
   logic [31:0] szs [7] = '{SZ_MASK, SZ_UPPER, SZ_HIGH16, SZ_TRACE,
      SZ_PKEY, SZ_DUTY, 32'h0};
   state_save_seq u_dut (.REF_CLK_I(clk), .RESET_N_I(rst_n),
      .START_I(start), .OP_I(op), .REQ_MASK_I(req), .VM_EXIT_I(vm_exit),
      .BUSY_O(busy), .DONE_O(done), .FAULT_O(fault),
      .OS_SAVE_ENABLE_I(os_en), .USER_STATE_MASK_I(um),
      .SUPERVISOR_STATE_MASK_I(sm), .MODE64_I(m64), .VEC_INSTR_OK_O(vec_ok),
      .QUERY_SUB_I(sub), .QUERY_OFFSET_O(q_ofs), .QUERY_SIZE_O(q_sz),
      .TRACE_ENABLE_BIT_I(tr_en), .TRACE_EN_WR_O(tr_wr),
      .TRACE_EN_VAL_O(tr_val), .PROTECTION_KEY_RIGHTS_I(protection_key_rights),
      .PKEY_CHECK_O(pk_chk), .RF_REQ_O(rf_req), .RF_WE_O(rf_we),
      .RF_COMP_O(rf_comp), .RF_IDX_O(rf_idx), .RF_WORD_O(rf_word),
      .RF_WDATA_O(rf_wd), .RF_RDATA_I(rf_rd), .MEM_REQ_O(m_req),
      .MEM_WE_O(m_we), .MEM_ADDR_O(m_addr), .MEM_BE_O(m_be),
      .MEM_WDATA_O(m_wd), .MEM_RDATA_I(m_rd), .MEM_ACK_I(m_ack),
      .MEM_FAULT_I(m_flt));
   save_area_model u_mem (.clk_i(clk), .rst_n_i(rst_n), .dly_i(dly),
      .flt_i(flt), .req_i(m_req), .we_i(m_we), .addr_i(m_addr),
      .be_i(m_be), .wd_i(m_wd), .rd_o(m_rd), .ack_o(m_ack), .flt_o(m_flt),
      .rf_req_i(rf_req), .rf_we_i(rf_we),
      .rf_sel_i({rf_comp, rf_idx, rf_word}), .rf_rd_o(rf_rd));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // trace enable owner, timeout
   always @(posedge clk) begin
      cyc++;
      if (tr_wr) tr_en <= tr_val;
      if (tr_wr && !tr_val) at_clr = u_mem.n_wr - wr0;
      if (rf_req && rf_we && rf_comp == CMP_TRACE && {rf_idx, rf_word} == 8'h00)
         tr_en <= rf_wd[0];
      if (cyc == 20000) begin
         num_errors++;
         stop_test();
      end
   end
   function automatic logic [63:0] pat(input logic [4:0] c,
      input logic [4:0] i, input logic [2:0] w);
      return {51'h0, c, i, w};
   endfunction
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic run(input logic [1:0] o, input logic [13:0] r,
      input logic e, input logic [13:0] u, input logic [13:0] s,
      input logic m);
      int n;
      n = 0;
      wr0 = u_mem.n_wr;
      rfw0 = u_mem.n_rfw;
      hi0 = u_mem.n_hi;
      @(posedge clk);
      {op, req, os_en, um, sm, m64, start} <= {o, r, e, u, s, m, 1'b1};
      @(posedge clk);
      start <= 1'b0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (done !== 1'b1 && n < 3000);
      if (n >= 3000) num_errors++;
   endtask
   task automatic tend();
      t++;
      $display("test %0d ended", t);
   endtask
   task automatic stop_test();
      $display("checks %0d errors %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // -----------------------------
   // scenarios
   // -----------------------------
   initial begin
      {rst_n, start, vm_exit, os_en, m64, tr_en, flt, op} = '0;
      {req, um, sm, sub, dly, t} = '0;
      protection_key_rights = 32'h1234_5678;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      foreach (subs[k]) begin
         @(posedge clk);
         sub <= subs[k];
         repeat (2) @(posedge clk);
         #1;
         chk(q_ofs, ofs[k]);
         chk(q_sz, szs[k]);
      end
      tend();
      run(OP_SAVE, 14'h02E0, 1'b1, 14'h02E0, 14'h0, 1'b1);
      chk(u_mem.n_wr - wr0, 201);
      chk(u_mem.mem[32'h458], pat(CMP_MASK, 5'd3, 3'd0));
      chk(u_mem.mem[32'h5A8], pat(CMP_UPPER, 5'd9, 3'd5));
      chk(u_mem.mem[32'hA78], pat(CMP_HIGH16, 5'd31, 3'd7));
      chk(u_mem.bel[OFS_PKEY], BE_PKEY);
      chk(vec_ok, 1'b1);
      u_mem.mem.delete();
      run(OP_SAVE, 14'h00E0, 1'b1, 14'h02E0, 14'h0, 1'b0);
      chk(u_mem.n_wr - wr0, 40);
      chk(u_mem.mem.exists(32'h580), 0);
      chk(u_mem.mem.exists(OFS_HIGH16), 0);
      run(OP_RESTORE, 14'h00E0, 1'b1, 14'h00E0, 14'h0, 1'b0);
      chk(u_mem.n_hi - hi0, 0);
      run(OP_RESTORE, 14'h00E0, 1'b1, 14'h00E0, 14'h0, 1'b1);
      chk(u_mem.n_hi - hi0, 160);
      tend();
      run(OP_SAVE, 14'h02E0, 1'b0, 14'h02E0, 14'h0, 1'b1);
      chk(fault, FLT_UNDEF);
      chk(u_mem.n_wr - wr0, 0);
      run(OP_SAVE, 14'h02E0, 1'b1, 14'h00C0, 14'h0, 1'b1);
      chk(u_mem.n_wr - wr0, 0);
      chk(vec_ok, 1'b0);
      tend();
      u_mem.mem.delete();
      @(posedge clk);
      tr_en <= 1'b1;
      run(OP_SAVE_SUP, 14'h2100, 1'b1, 14'h0, 14'h0100, 1'b1);
      chk(u_mem.n_wr - wr0, 16);
      chk(u_mem.mem[32'h48], 64'h0);
      chk(u_mem.mem[32'h78], 64'h0);
      chk(at_clr, 1);
      chk(tr_en, 1'b0);
      u_mem.mem.delete();
      run(OP_SAVE_SUP, 14'h2100, 1'b1, 14'h0, 14'h2000, 1'b1);
      chk(u_mem.n_wr - wr0, 1);
      chk(u_mem.mem[32'h0], pat(CMP_DUTY, 5'd0, 3'd0));
      chk(u_mem.bel[32'h0], BE_FULL);
      run(OP_SAVE_SUP, 14'h2000, 1'b1, 14'h0, 14'h0100, 1'b1);
      chk(u_mem.n_wr - wr0, 0);
      tend();
      @(posedge clk);
      tr_en <= 1'b1;
      dly <= 4'h4;
      at_clr = 0;
      fork
         run(OP_SAVE_SUP, 14'h0100, 1'b1, 14'h0, 14'h0100, 1'b1);
         begin
            wait (at_clr == 1);
            @(posedge clk);
            vm_exit <= 1'b1;
         end
      join
      repeat (2) @(posedge clk);
      {vm_exit, dly, flt} <= 6'h01;
      #1;
      chk(fault, FLT_VMEXIT);
      chk(tr_en, 1'b1);
      run(OP_SAVE_SUP, 14'h0100, 1'b1, 14'h0, 14'h0100, 1'b1);
      chk(fault, FLT_MEM);
      chk(tr_en, 1'b1);
      run(OP_RESTORE_SUP, 14'h0100, 1'b1, 14'h0, 14'h0100, 1'b1);
      chk(fault, FLT_GP);
      chk(u_mem.n_rfw - rfw0, 0);
      tend();
      @(posedge clk);
      {tr_en, flt} <= 2'b00;
      u_mem.mem[32'h0] = 64'h1;
      fork
         run(OP_RESTORE_SUP, 14'h0100, 1'b1, 14'h0, 14'h0100, 1'b1);
         begin
            repeat (12) @(posedge clk);
            flt <= 1'b1;
         end
      join
      chk(fault, FLT_MEM);
      chk(tr_en, 1'b0);
      @(posedge clk);
      flt <= 1'b0;
      run(OP_RESTORE_SUP, 14'h0100, 1'b1, 14'h0, 14'h0100, 1'b1);
      @(posedge clk);
      #1;
      chk(tr_en, 1'b1);
      fork
         run(OP_RESTORE, 14'h0200, 1'b1, 14'h0200, 14'h0, 1'b1);
         begin
            wait (busy === 1'b1);
            @(posedge clk);
            protection_key_rights <= 32'h0BAD_F00D;
         end
      join
      chk(pk_chk, 32'h1234_5678);
      tend();
      stop_test();
   end
endmodule // extended_state_save_layout_tb_top
